/* design/wdt_sleep_ctl.sv */
// watchdog, shared scaler and sleep/wake control, wishbone register slave
// assumes wdt oscillator, master clear and interrupt requests arrive asynchronously
// What this block does
// [RQ1] watchdog counts on its own oscillator
// [RQ2] expiry while running causes watchdog reset
// [RQ3] expiry while asleep wakes, no reset
// [RQ4] expiry while running or asleep clears time-out flag
// [RQ5] configuration enable bit disables watchdog
// [RQ6] one scaler shared, select and ratio
// [RQ7] clear and sleep reset count, postscaler
// [RQ8] clear zeroes scaler only when assigned to watchdog, keeps assignment select
// [RQ9] sleep clears watchdog and pdFlag, sets toFlag, stops oscillator
// [RQ10] port drive state frozen during sleep
// [RQ11] master clear resets; others resume execution
// [RQ12] power-down flag set at power-up, cleared by sleep
// [RQ13] only clockless interrupt sources wake sleep
// [RQ14] sleep prefetches next program address
// [RQ15] individual enable wakes; global enable ignored
// [RQ16] after wake, branch to vector if enabled
// [RQ17] pending interrupt makes sleep a no-op
// [RQ18] late interrupt: sleep completes, then wakes
// [RQ19] software should clear watchdog before sleep
// [RQ20] global enable gates interrupts, reset clears
// [RQ21] base time-out period is a parameter
`timescale 1ns/10ps
module wdt_sleep_ctl
	import wdt_sleep_pkg::*;
#(
	parameter int BASE_PERIOD = 4608,   // oscillator cycles per base time-out
	parameter int NUM_IRQ     = 8,      // interrupt sources
	parameter int PORT_W      = 8       // port pins held during sleep
)(
	input  wire logic                  ref_clk,
	input  wire logic                  rst,
	// wishbone classic slave
	input  wire logic                  wbCyc,
	input  wire logic                  wbStb,
	input  wire logic                  wbWe,
	input  wire logic [ADDR_W-1:0]     wbAdr,
	input  wire logic [3:0]            wbSel,
	input  wire logic [31:0]           wbDatI,
	output logic      [31:0]           wbDatO,
	output logic                       wbAck,
	// asynchronous inputs
	input  wire logic                  wdtOscIn,
	input  wire logic                  masterClearPinN,
	input  wire logic [NUM_IRQ-1:0]    irqFlags,
	input  wire logic [NUM_IRQ-1:0]    irqEnables,
	input  wire logic [NUM_IRQ-1:0]    irqClockless,
	// port drive from the core
	input  wire logic [PORT_W-1:0]     portOut,
	input  wire logic [PORT_W-1:0]     portOe,
	input  wire logic [12:0]           pcNow,
	// to the core and pins
	output logic [PORT_W-1:0]          portOutHeld,
	output logic [PORT_W-1:0]          portOeHeld,
	output logic                       mainOscEnable,
	output logic                       deviceReset,
	output logic                       timer0ScalerTick,
	output logic [12:0]                fetchAddr,
	output core_ctl_t                  coreCtl
);
	// counter width for the base period
	localparam int CNT_W = $clog2(BASE_PERIOD + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(BASE_PERIOD - 1);

	// all state in one struct
	typedef struct packed {
		logic [SYNC_W-1:0]       oscSync;     // wdt oscillator synchroniser
		logic [SYNC_W-1:0]       mrstSync;    // master clear synchroniser
		logic [NUM_IRQ-1:0]      irqS1;       // interrupt sync stage 1
		logic [NUM_IRQ-1:0]      irqS2;
		logic [NUM_IRQ-1:0]      irqS3;
		logic                    oscLevel;    // accepted oscillator level
		logic                    mrstLevel;   // accepted master clear level (low = reset)
		logic [NUM_IRQ-1:0]      irqLevel;
		logic [CNT_W-1:0]        wdtCount;
		logic [7:0]              scaler;      // shared prescaler / postscaler count
		logic [7:0]              option;
		logic [7:0]              cfgWord;     // model of the nonvolatile configuration word
		logic                    toFlag;      // high = no time-out
		logic                    pdFlag;      // high = no sleep executed
		logic                    globalEn;    // global interrupt enable
		mode_t                   mode;
		logic [PORT_W-1:0]       heldOut;
		logic [PORT_W-1:0]       heldOe;
		logic                    oscEn;
		logic                    devRst;
		logic                    t0Tick;
		logic [12:0]             fetch;
		core_ctl_t               ctl;
		logic [31:0]             datO;
		logic                    ack;
	} state_t;

	state_t cur_reg;
	state_t cur_next;

	// ratio decode, used by both scaler consumers
	function automatic logic scalerHit(input logic [7:0] cnt, input logic [2:0] ratio, input logic toWdt);
		logic [7:0] mask;
		mask = 8'hFF >> (3'h7 - ratio);
		if (toWdt)
			mask = mask >> 1;   // watchdog postscaler runs 1:1 at ratio 0
		scalerHit = ((cnt & mask) == mask);
	endfunction : scalerHit

	// byte address to register index
	function automatic logic [15:0] regIndex(input logic [ADDR_W-1:0] adr);
		regIndex = adr[ADDR_W-1:2];
	endfunction : regIndex

	// next-state logic
	always_comb
	begin
		logic        oscRise;
		logic        wdtOn;
		logic        toWdt;
		logic        baseDone;
		logic        expire;
		logic        doClear;
		logic        doSleep;
		logic        pendWake;
		logic        pendAny;
		logic        wbReq;
		logic [15:0] idx;
		logic [7:0]  wdat;
		oscRise  = 1'b0;
		wdtOn    = 1'b0;
		toWdt    = 1'b0;
		baseDone = 1'b0;
		expire   = 1'b0;
		doClear  = 1'b0;
		doSleep  = 1'b0;
		pendWake = 1'b0;
		pendAny  = 1'b0;
		wbReq    = 1'b0;
		idx      = 16'h0000;
		wdat     = 8'h00;
		cur_next = cur_reg;

		// synchronisers: change counts when stages 2 and 3 agree
		cur_next.oscSync  = {cur_reg.oscSync[SYNC_W-2:0], wdtOscIn};
		cur_next.mrstSync = {cur_reg.mrstSync[SYNC_W-2:0], masterClearPinN};
		cur_next.irqS1    = irqFlags & irqEnables;
		cur_next.irqS2    = cur_reg.irqS1;
		cur_next.irqS3    = cur_reg.irqS2;
		if (cur_reg.oscSync[1] == cur_reg.oscSync[2])
			cur_next.oscLevel = cur_reg.oscSync[2];
		if (cur_reg.mrstSync[1] == cur_reg.mrstSync[2])
			cur_next.mrstLevel = cur_reg.mrstSync[2];
		for (int i = 0; i < NUM_IRQ; i++)
			if (cur_reg.irqS2[i] == cur_reg.irqS3[i])
				cur_next.irqLevel[i] = cur_reg.irqS3[i];

		// one-cycle outputs default low
		cur_next.ctl    = '0;
		cur_next.devRst = 1'b0;
		cur_next.t0Tick = 1'b0;
		cur_next.ack    = 1'b0;

		// watchdog on the oscillator's own edges, free of the main clock
		oscRise  = cur_next.oscLevel & ~cur_reg.oscLevel;                                   // RQ1
		wdtOn    = cur_reg.cfgWord[CFG_WDT_EN];                                              // RQ5
		toWdt    = cur_reg.option[OPT_ASSIGN];                                               // RQ6
		baseDone = oscRise && (cur_reg.wdtCount == CNT_LAST);                                // RQ21
		// interrupts: individual enables only, global enable not consulted for wake
		pendAny  = |cur_reg.irqLevel;                                                        // RQ15
		// asleep only clockless sources count
		pendWake = |(cur_reg.irqLevel & irqClockless);                                       // RQ13

		// wishbone decode
		wbReq = wbCyc && wbStb && !cur_reg.ack;
		idx   = regIndex(wbAdr);
		wdat  = wbSel[0] ? wbDatI[7:0] : 8'h00;
		if (wbReq)
		begin
			cur_next.ack  = 1'b1;
			cur_next.datO = 32'h0000_0000;
			case (idx)
				OPTION_IDX, OPTION_IDX2: cur_next.datO[7:0] = cur_reg.option;
				CONFIG_IDX:  cur_next.datO[7:0] = cur_reg.cfgWord;
				STATUS_IDX:  cur_next.datO[7:0] = 8'({cur_reg.toFlag, cur_reg.pdFlag}) << ST_PD;
				INTCTL_IDX:  cur_next.datO[7:0] = 8'(cur_reg.globalEn) << IC_GLB_EN;
				default:     cur_next.datO = 32'h0000_0000;   // unmapped reads zero
			endcase
			if (wbWe && wbSel[0])
			begin
				case (idx)
					OPTION_IDX, OPTION_IDX2: cur_next.option = wdat;
					CONFIG_IDX:  cur_next.cfgWord = wdat;
					INTCTL_IDX:  cur_next.globalEn = wdat[IC_GLB_EN];                      // RQ20
					CMD_IDX:
					begin
						doClear = wdat[CMD_WDCLR];
						doSleep = wdat[CMD_SLEEP] && (cur_reg.mode == RUN);
						if (wdat[CMD_RETINT])
							cur_next.globalEn = 1'b1;
					end
					default: ;   // writes elsewhere ignored
				endcase
			end
		end

		// watchdog count and shared scaler
		if (toWdt)
		begin
			if (baseDone)
			begin
				cur_next.wdtCount = '0;
				cur_next.scaler   = cur_reg.scaler + 8'h01;
				expire = wdtOn && scalerHit(cur_reg.scaler, cur_reg.option[OPT_RATIO_LO +: 3], 1'b1);
				if (expire)
					cur_next.scaler = 8'h00;
			end
			else if (oscRise)
				cur_next.wdtCount = cur_reg.wdtCount + CNT_W'(1);
		end
		else
		begin
			// timer0 prescaler, counted on the core clock in this model
			cur_next.scaler = cur_reg.scaler + 8'h01;
			cur_next.t0Tick = scalerHit(cur_reg.scaler, cur_reg.option[OPT_RATIO_LO +: 3], 1'b0);
			if (baseDone)
				cur_next.wdtCount = '0;
			else if (oscRise)
				cur_next.wdtCount = cur_reg.wdtCount + CNT_W'(1);
			expire = wdtOn && baseDone;
		end
		if (!wdtOn)
			cur_next.wdtCount = '0;                                                          // RQ5

		// clear instruction: count and, if assigned, postscaler; select kept
		if (doClear)
		begin
			cur_next.wdtCount = '0;                                                          // RQ7
			if (toWdt)
				cur_next.scaler = 8'h00;                                                     // RQ8
			cur_next.toFlag = 1'b1;
			cur_next.pdFlag = 1'b1;
		end

		// sleep entry
		if (doSleep)
		begin
			if (pendAny)
			begin
				// pending enabled interrupt: sleep is a no-op
				cur_next.mode = RUN;                                                         // RQ17
			end
			else
			begin
				cur_next.wdtCount = '0;                                                      // RQ7 RQ9
				if (toWdt)
					cur_next.scaler = 8'h00;                                                 // RQ7
				cur_next.pdFlag = 1'b0;                                                      // RQ9 RQ12
				cur_next.toFlag = 1'b1;                                                      // RQ9
				cur_next.oscEn  = 1'b0;                                                      // RQ9
				cur_next.heldOut = portOut;                                                  // RQ10
				cur_next.heldOe  = portOe;                                                   // RQ10
				cur_next.fetch   = pcNow + 13'h0001;                                         // RQ14
				cur_next.ctl.prefetchNext = 1'b1;                                            // RQ14
				cur_next.mode = SLEEP;
			end
		end

		// follow the core's ports when awake, freeze them asleep
		if (cur_reg.mode == RUN && !doSleep)
		begin
			cur_next.heldOut = portOut;
			cur_next.heldOe  = portOe;
			cur_next.fetch   = pcNow;
		end

		// mode sequencing
		case (cur_reg.mode)
			RUN:
			begin
				if (expire)
				begin
					cur_next.devRst = 1'b1;                                                  // RQ2
					cur_next.ctl.wdtReset = 1'b1;                                            // RQ2
					cur_next.toFlag = 1'b0;                                                  // RQ4
					cur_next.globalEn = 1'b0;                                                // RQ20
				end
			end
			SLEEP:
			begin
				// sleep already complete: late interrupt wakes at once
				if (expire)
				begin
					cur_next.toFlag = 1'b0;                                                  // RQ3 RQ4
					cur_next.mode   = WAKE;                                                  // RQ3 RQ11
				end
				else if (pendWake)
					cur_next.mode = WAKE;                                                    // RQ11 RQ18
			end
			WAKE:
			begin
				cur_next.oscEn = 1'b1;
				cur_next.ctl.wakeUp = 1'b1;                                                  // RQ11
				// prefetched instruction runs first, then vector if globally enabled
				cur_next.ctl.vectorTake = cur_reg.globalEn && pendAny;                       // RQ16
				if (cur_reg.globalEn && pendAny)
					cur_next.fetch = INT_VECTOR;                                             // RQ16
				cur_next.mode = RUN;
			end
			default: cur_next.mode = RUN;
		endcase

		// master clear: the only wake source that resets
		if (!cur_reg.mrstLevel)
		begin
			cur_next.devRst   = 1'b1;                                                        // RQ11
			cur_next.mode     = RUN;
			cur_next.oscEn    = 1'b1;
			cur_next.globalEn = 1'b0;                                                        // RQ20
			cur_next.wdtCount = '0;
			cur_next.scaler   = 8'h00;
			cur_next.option   = OPTION_RST;
		end
	end

	// state register
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			cur_reg          <= '0;
			cur_reg.mrstSync <= '1;
			cur_reg.mrstLevel <= 1'b1;
			cur_reg.option   <= OPTION_RST;
			cur_reg.cfgWord  <= CONFIG_RST;
			cur_reg.toFlag   <= 1'b1;   // power-up: both flags set
			cur_reg.pdFlag   <= 1'b1;   // RQ12
			cur_reg.globalEn <= 1'b0;   // RQ20
			cur_reg.mode     <= RUN;
			cur_reg.oscEn    <= 1'b1;
		end
		else
			cur_reg <= cur_next;
	end

	// outputs straight from flops
	assign wbDatO           = cur_reg.datO;
	assign wbAck            = cur_reg.ack;
	assign portOutHeld      = cur_reg.heldOut;
	assign portOeHeld       = cur_reg.heldOe;
	assign mainOscEnable    = cur_reg.oscEn;
	assign deviceReset      = cur_reg.devRst;
	assign timer0ScalerTick = cur_reg.t0Tick;
	assign fetchAddr        = cur_reg.fetch;
	assign coreCtl          = cur_reg.ctl;
endmodule : wdt_sleep_ctl

/* design/wdt_sleep_pkg.sv */
// package for the watchdog / sleep-wake controller: register map, field positions, carriers
// assumes a single 250 MHz core clock and a classic wishbone master
package wdt_sleep_pkg;
	// register word addresses (printed offsets, not multiples of four: byte address = 4 * index)
	localparam logic [15:0] OPTION_IDX  = 16'h0081;
	localparam logic [15:0] OPTION_IDX2 = 16'h0181;
	localparam logic [15:0] CONFIG_IDX  = 16'h2007;
	localparam logic [15:0] STATUS_IDX  = 16'h0003;   // own choice: status flags
	localparam logic [15:0] INTCTL_IDX  = 16'h000B;   // own choice: interrupt control
	localparam logic [15:0] CMD_IDX     = 16'h0010;   // own choice: instruction strobes
	localparam int          ADDR_W      = 18;
	// option register fields
	localparam int OPT_ASSIGN   = 3;
	localparam int OPT_RATIO_LO = 0;
	localparam logic [7:0] OPTION_RST = 8'hFF;
	// configuration word fields
	localparam int CFG_WDT_EN = 2;
	localparam logic [7:0] CONFIG_RST = 8'hFF;
	// status fields
	localparam int ST_PD = 3;
	localparam int ST_TO = 4;
	// interrupt control fields
	localparam int IC_GLB_EN = 7;
	// command register bits
	localparam int CMD_WDCLR  = 0;
	localparam int CMD_SLEEP  = 1;
	localparam int CMD_RETINT = 2;
	// interrupt vector
	localparam logic [12:0] INT_VECTOR = 13'h0004;
	// input synchroniser depth
	localparam int SYNC_W = 3;
	// reset, wake and fetch events presented to the core
	typedef struct packed {
		logic wdtReset;    // full device reset, watchdog cause
		logic wakeUp;      // resume after sleep
		logic vectorTake;  // branch to interrupt vector after wake
		logic prefetchNext;// fetch pc+1 while sleeping
	} core_ctl_t;
	typedef enum logic [2:0] {
		RUN   = 3'b001,
		SLEEP = 3'b010,
		WAKE  = 3'b100
	} mode_t;
endpackage : wdt_sleep_pkg

/* test/core_model.sv */
// core model: program counter and port drive seen by the controller
// assumes wake and reset pulses last one cycle
`timescale 1ns/10ps
module core_model (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        wake,
	input  wire logic        devRst,
	output logic      [12:0] pcNow,
	output logic      [7:0]  portOut,
	output logic      [7:0]  portOe
);
	// pc steps only on wake, steady across sleep entry
	always_ff @(posedge ref_clk or posedge rst)
		if (rst)
		begin
			pcNow   <= 13'h0100;
			portOut <= 8'h00;
			portOe  <= 8'h00;
		end
		else
		begin
			if (devRst)
				pcNow <= 13'h0000;
			else if (wake)
				pcNow <= pcNow + 13'h0001;
			// drive keeps moving so a missed freeze shows
			portOut <= portOut + 8'h35;
			portOe  <= ~portOe;
		end
endmodule : core_model

/* test/test_wdt_sleep_ctl.sv */
// bench for the watchdog / sleep controller: bus, sleep, wake and reset cases
// assumes core_model and the bound checker compiled first
`timescale 1ns/10ps
module test_wdt_sleep_ctl;
	import wdt_sleep_pkg::*;
	logic            ref_clk, rst, wbCyc, wbStb, wbWe, wbAck, masterClearPinN;
	logic [17:0]     wbAdr;
	logic [3:0]      wbSel;
	logic [31:0]     wbDatI, wbDatO;
	logic [7:0]      irqFlags, irqEnables, irqClockless, portOut, portOe, portOutHeld, portOeHeld, q, v;
	logic [12:0]     pcNow, fetchAddr;
	logic            mainOscEnable, deviceReset, timer0ScalerTick;
	logic            wdtOscIn = 1'b0;
	core_ctl_t       coreCtl;
	int              errorCnt, totalChecks, nRst, nDev, nWake, nVec, nTick, oscDiv;
	wdt_sleep_ctl #(.BASE_PERIOD(4)) DUT (.ref_clk, .rst, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel, .wbDatI,
		.wbDatO, .wbAck, .wdtOscIn, .masterClearPinN, .irqFlags, .irqEnables, .irqClockless, .portOut,
		.portOe, .pcNow, .portOutHeld, .portOeHeld, .mainOscEnable, .deviceReset, .timer0ScalerTick,
		.fetchAddr, .coreCtl);
	core_model PART (.ref_clk, .rst, .wake(coreCtl.wakeUp), .devRst(deviceReset), .pcNow, .portOut, .portOe);
	initial
	begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	// watchdog oscillator, one rise every ten cycles
	always @(posedge ref_clk)
	begin
		oscDiv <= (oscDiv == 4) ? 0 : oscDiv + 1;
		if (oscDiv == 4)
			wdtOscIn <= ~wdtOscIn;
	end
	// event counters, pulses last one cycle except deviceReset, held high while master clear is low
	always @(posedge ref_clk)
	begin
		if (coreCtl.wdtReset === 1'b1) nRst++;
		if (deviceReset === 1'b1) nDev++;
		if (coreCtl.wakeUp === 1'b1) nWake++;
		if (coreCtl.vectorTake === 1'b1) nVec++;
		if (timer0ScalerTick === 1'b1) nTick++;
	end
	// one classic cycle, held until ack
	task automatic wbx(input logic we, input logic [15:0] idx, input logic [7:0] d);
		@(posedge ref_clk);
		wbCyc  <= 1'b1;
		wbStb  <= 1'b1;
		wbWe   <= we;
		wbAdr  <= {idx, 2'b00};
		wbDatI <= {24'h000000, d};
		do @(posedge ref_clk); while (wbAck !== 1'b1);
		q = wbDatO[7:0];
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
	endtask : wbx
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		totalChecks++;
		if (g !== e)
		begin
			$display("ERROR %s expected %h seen %h", nm, e, g);
			errorCnt++;
		end
	endtask : chk
	task automatic stat(input logic t, input logic p);
		wbx(1'b0, STATUS_IDX, 8'h00);
		chk("to_flag", t, q[ST_TO]);
		chk("pd_flag", p, q[ST_PD]);
	endtask : stat
	// bounded wait for a counter to move
	task automatic waitEv(ref int c, input int lim);
		int b;
		b = c;
		for (int i = 0; i < lim && c == b; i++)
			@(posedge ref_clk);
	endtask : waitEv
	task automatic summarize;
		$display("checks %0d errors %0d", totalChecks, errorCnt);
		if (errorCnt == 0 && totalChecks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : summarize
	// whole run is some 3000 cycles; 25000 means a hang
	initial
	begin
		#100000;
		errorCnt++;
		summarize();
	end
	initial
	begin
		int r0, w0, v0, t0;
		{rst, wbCyc, wbStb, wbWe, wbAdr, wbDatI, irqFlags, irqEnables, irqClockless} = '0;
		rst = 1'b1;
		wbSel = 4'h1;
		masterClearPinN = 1'b1;
		void'($urandom(32'hED7F));
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		wbx(1'b0, OPTION_IDX, 8'h00);
		chk("option", OPTION_RST, q);
		wbx(1'b0, CONFIG_IDX, 8'h00);
		chk("config", CONFIG_RST, q);
		stat(1'b1, 1'b1);
		wbx(1'b0, INTCTL_IDX, 8'h00);
		chk("glb_en", 8'h00, q[IC_GLB_EN]);
		wbx(1'b0, 16'h0055, 8'h00);
		chk("unmapped", 8'h00, q);
		wbx(1'b1, CMD_IDX, 8'h04);
		wbx(1'b0, INTCTL_IDX, 8'h00);
		chk("glb_en", 8'h01, q[IC_GLB_EN]);
		wbx(1'b1, INTCTL_IDX, 8'h00);
		$display("test reset_values done");
		// scaler to timer0 with watchdog fused off
		wbx(1'b1, CONFIG_IDX, 8'hFB);
		v = 8'($urandom) & 8'hD7;
		wbx(1'b1, OPTION_IDX2, v);
		wbx(1'b0, OPTION_IDX, 8'h00);
		chk("option", v, q);
		{r0, t0} = {nRst, nTick};
		repeat (2200) @(posedge ref_clk);
		chk("tick", 8'h01, nTick != t0);
		chk("wdt_off", r0, nRst);
		wbx(1'b1, OPTION_IDX, 8'hFF);
		t0 = nTick;
		repeat (300) @(posedge ref_clk);
		chk("no_tick", 8'h00, nTick != t0);
		wbx(1'b1, CONFIG_IDX, 8'hFF);
		$display("test scaler done");
		// clears hold off a 40 cycle expiry; clear first so no expiry lands before r0
		wbx(1'b1, CMD_IDX, 8'h01);
		wbx(1'b1, OPTION_IDX, 8'h08);
		r0 = nRst;
		repeat (30)
		begin
			wbx(1'b1, CMD_IDX, 8'h01);
			repeat ($urandom_range(12, 2)) @(posedge ref_clk);
		end
		chk("cleared", r0, nRst);
		wbx(1'b0, OPTION_IDX, 8'h00);
		chk("option", 8'h08, q);
		// fresh clear, then look just short of the earliest possible expiry
		wbx(1'b1, CMD_IDX, 8'h01);
		repeat (28) @(posedge ref_clk);
		chk("early", r0, nRst);
		waitEv(nRst, 300);
		chk("wdt_reset", r0 + 1, nRst);
		stat(1'b0, 1'b1);
		$display("test wdt_reset done");
		wbx(1'b1, OPTION_IDX, 8'h08);
		wbx(1'b1, CMD_IDX, 8'h01);
		wbx(1'b1, CMD_IDX, 8'h02);
		{r0, w0} = {nRst, nWake};
		repeat (3) @(posedge ref_clk);
		chk("osc_off", 8'h00, mainOscEnable);
		stat(1'b1, 1'b0);
		waitEv(nWake, 300);
		chk("wdt_wake", w0 + 1, nWake);
		chk("no_reset", r0, nRst);
		stat(1'b0, 1'b0);
		repeat (4) @(posedge ref_clk);
		chk("osc_on", 8'h01, mainOscEnable);
		$display("test wdt_wake done");
		for (int g = 0; g < 2; g++)
		begin
			wbx(1'b1, OPTION_IDX, 8'hFF);
			wbx(1'b1, INTCTL_IDX, 8'(g << 7));
			irqEnables <= 8'h03;
			irqClockless <= 8'h01;
			wbx(1'b1, CMD_IDX, 8'h01);
			wbx(1'b1, CMD_IDX, 8'h02);
			{w0, v0} = {nWake, nVec};
			irqFlags <= 8'h02;
			repeat (40) @(posedge ref_clk);
			chk("clocked_src", w0, nWake);
			irqFlags <= 8'h03;
			waitEv(nWake, 60);
			chk("irq_wake", w0 + 1, nWake);
			chk("vector", v0 + g, nVec);
			irqFlags <= 8'h00;
			repeat (8) @(posedge ref_clk);
		end
		$display("test irq_wake done");
		// pending interrupt turns sleep into a no-op
		wbx(1'b1, INTCTL_IDX, 8'h00);
		irqEnables <= 8'h01;
		irqFlags <= 8'h01;
		wbx(1'b1, CMD_IDX, 8'h01);
		repeat (6) @(posedge ref_clk);
		wbx(1'b1, CMD_IDX, 8'h02);
		repeat (6) @(posedge ref_clk);
		chk("nop_osc", 8'h01, mainOscEnable);
		stat(1'b1, 1'b1);
		{irqFlags, irqEnables} <= 16'h0000;
		$display("test sleep_nop done");
		// let the pending level drain so this sleep really starts
		repeat (6) @(posedge ref_clk);
		wbx(1'b1, CMD_IDX, 8'h02);
		repeat (4) @(posedge ref_clk);
		chk("mrst_asleep", 8'h00, mainOscEnable);
		r0 = nDev;
		masterClearPinN <= 1'b0;
		repeat (10) @(posedge ref_clk);
		chk("mrst", 8'h01, nDev != r0);
		masterClearPinN <= 1'b1;
		repeat (10) @(posedge ref_clk);
		chk("mrst_osc", 8'h01, mainOscEnable);
		$display("test mrst done");
		summarize();
	end
endmodule : test_wdt_sleep_ctl

/* test/wdt_sleep_ctl_asserts.sv */
// port-level checks for the watchdog / sleep controller
// assumes one clock domain, rst async high
`timescale 1ns/10ps
module wdt_sleep_ctl_asserts
	import wdt_sleep_pkg::*;
#(
	parameter int PORT_W = 8
)(
	input wire logic                     ref_clk,
	input wire logic                     rst,
	input wire logic                     wbCyc,
	input wire logic                     wbStb,
	input wire logic                     wbAck,
	input wire logic                     masterClearPinN,
	input wire logic [12:0]              pcNow,
	input wire logic [PORT_W-1:0]        portOutHeld,
	input wire logic [PORT_W-1:0]        portOeHeld,
	input wire logic                     mainOscEnable,
	input wire logic                     deviceReset,
	input wire logic [12:0]              fetchAddr,
	input wire wdt_sleep_pkg::core_ctl_t coreCtl
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// bus answer comes one cycle after the take, and only once
	a_ack_next: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
		else $error("bus request not answered next cycle");
	a_ack_single: assert property (wbAck |=> !wbAck)
		else $error("ack longer than one cycle");
	// pins frozen for the whole sleep
	a_port_frozen: assert property (!mainOscEnable [*2] |-> $stable(portOutHeld) && $stable(portOeHeld))
		else $error("port drive moved while asleep");
	a_prefetch_next: assert property (coreCtl.prefetchNext |-> ##[0:2] fetchAddr == pcNow + 13'h1)
		else $error("prefetch address not pc plus one");
	a_vector_fetch: assert property (coreCtl.vectorTake |-> ##[0:2] fetchAddr == INT_VECTOR)
		else $error("vectored wake did not fetch vector");
	a_wake_no_reset: assert property (coreCtl.wakeUp |-> !coreCtl.wdtReset && !deviceReset)
		else $error("wake came with a reset");
	a_wdt_reset_pulse: assert property (coreCtl.wdtReset |-> ##[0:1] deviceReset)
		else $error("watchdog reset without device reset");
	// a reset cause only while the core clock ran
	a_reset_awake: assert property (coreCtl.wdtReset |-> $past(mainOscEnable))
		else $error("watchdog reset raised while asleep");
	// sync chain plus agreement is under six cycles
	a_master_clear_pin_reset: assert property (!masterClearPinN [*6] |-> deviceReset)
		else $error("master clear held low without reset");
endmodule : wdt_sleep_ctl_asserts

bind wdt_sleep_ctl wdt_sleep_ctl_asserts #(.PORT_W(PORT_W)) chkr (.ref_clk, .rst, .wbCyc, .wbStb,
	.wbAck, .masterClearPinN, .pcNow, .portOutHeld, .portOeHeld, .mainOscEnable, .deviceReset,
	.fetchAddr, .coreCtl);
